// ### dv/afpmc_assertions.sv
// Checker of link framing, output release and host pacing
`timescale 1ns/10ps
`default_nettype none
module afpmc_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Link signals
  input wire logic frameSelN,
  input wire logic serialClk,
  input wire logic resultOut,
  input wire logic resultOutEn
);
  logic       sclkPrev_r;
  logic [4:0] fallCnt_r;
  logic [4:0] fallCnt_nxt;
  wire        sclkFall;

  // Falls of the link clock counted within one frame
  assign sclkFall    = sclkPrev_r & ~serialClk;
  assign fallCnt_nxt = frameSelN ? 5'h0 : fallCnt_r + {4'h0, sclkFall};

  // Previous link clock level
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) sclkPrev_r <= 1'h0;
    else          sclkPrev_r <= serialClk;

  // Fall counter register
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) fallCnt_r <= 5'h0;
    else          fallCnt_r <= fallCnt_nxt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // High phase of the link clock lasts four system cycles
  sequence sclkHigh;
    serialClk [*4] ##1 !serialClk;
  endsequence

  AST_OUT_ON: assert property ($fell(frameSelN)
    |-> ##[1:5] resultOutEn)
    else $error("output not driven after frame start");
  AST_OUT_OFF: assert property ($rose(frameSelN)
    |-> ##[0:4] !resultOutEn)
    else $error("output not released after early frame end");
  AST_IDLE_OFF: assert property (frameSelN [*5] |-> !resultOutEn)
    else $error("output driven between frames");
  AST_TRI_16: assert property (fallCnt_r == 5'd16
    |-> ##[0:5] !resultOutEn)
    else $error("output not released after last fall");
  AST_LEAD_ZERO: assert property (!frameSelN && resultOutEn
    && fallCnt_r < 5'd3 |-> !resultOut)
    else $error("leading bit not zero");
  AST_QUIET: assert property ($rose(frameSelN) |-> frameSelN [*5])
    else $error("frame select lowered inside quiet interval");
  AST_SCLK_IDLE: assert property (frameSelN |-> !serialClk)
    else $error("link clock high outside a frame");
  AST_SCLK_HALF: assert property ($rose(serialClk) |-> sclkHigh)
    else $error("link clock high phase wrong length");
  AST_FRAME_MAX: assert property (!frameSelN |-> fallCnt_r <= 5'd16)
    else $error("more than sixteen falls in a frame");
endmodule : afpmc_assertions
`default_nettype wire

// ### dv/test_adc_frame_power_mode_control.sv
// Testbench joining host and converter ends across the link
`timescale 1ns/10ps
`default_nettype none
module test_adc_frame_power_mode_control;
  import afpmc_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        startReq;
  logic [4:0]  edgeCount;
  logic [11:0] sampleIn;
  logic        poweredUp;
  logic        analogOn;
  logic        trackMode;
  logic        frameActive;
  logic        busy;
  logic        wordValid;
  logic [15:0] wordOut;
  logic        gotValid;
  logic [15:0] gotWord;
  logic        trackMid;
  logic        activeMid;
  logic        trackEnd;
  logic        activeEnd;
  int          miscompares;
  int          check_count;

  afpmc_link_if link ();
  afpmc_device u_afpmc_device (.clk(clk), .reset_n(reset_n),
    .link(link.device), .sampleIn(sampleIn), .poweredUp(poweredUp),
    .analogOn(analogOn), .trackMode(trackMode), .frameActive(frameActive));
  afpmc_host u_afpmc_host (.clk(clk), .reset_n(reset_n), .link(link.host),
    .startReq(startReq), .edgeCount(edgeCount), .busy(busy),
    .wordValid(wordValid), .wordOut(wordOut));
  afpmc_assertions u_afpmc_assertions (.clk(clk), .reset_n(reset_n),
    .frameSelN(link.frameSelN), .serialClk(link.serialClk),
    .resultOut(link.resultOut), .resultOutEn(link.resultOutEn));

  // System clock
  always #5 clk = ~clk;

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // Compare one value and count it
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One host frame of n falls; sample input inverts 30 cycles in, if the frame lasts that long
  task automatic frame(input logic [4:0] n);
    int i;
    gotValid  = 1'h0;
    trackMid  = 1'hx;
    activeMid = 1'hx;
    trackEnd  = 1'hx;
    activeEnd = 1'hx;
    @(posedge clk);
    startReq  <= 1'h1;
    edgeCount <= n;
    @(posedge clk);
    startReq <= 1'h0;
    for (i = 0; i < 400 && (i < 2 || busy === 1'h1); i++)
    begin
      @(posedge clk);
      if (i == 30) sampleIn <= ~sampleIn;
      #1;
      // Mid-frame snapshot of hold and frame state
      if (i == 30)
      begin
        trackMid  = trackMode;
        activeMid = frameActive;
      end
      if (wordValid === 1'h1)
      begin
        gotValid  = 1'h1;
        gotWord   = wordOut;
        trackEnd  = trackMode;
        activeEnd = frameActive;
      end
    end
    if (i == 400)
    begin
      miscompares++;
      tally_and_finish();
    end
  endtask : frame

  // Frame then power state check
  task automatic pwr(input logic [4:0] n, input logic up);
    frame(n);
    chk("poweredUp", {15'h0, up}, {15'h0, poweredUp});
    chk("analogOn", {15'h0, up}, {15'h0, analogOn});
  endtask : pwr

  // Reset state
  task automatic t_reset;
    chk("poweredUp", 16'h1, {15'h0, poweredUp});
    chk("trackMode", 16'h1, {15'h0, trackMode});
  endtask : t_reset

  // Full frames give the word latched at frame start
  task automatic t_full;
    logic [11:0] s [3] = '{12'ha5c, 12'hfff, 12'h801};
    logic [15:0] exp;
    foreach (s[k])
    begin
      sampleIn <= s[k];
      frame(5'd16);
      exp = {4'h0, s[k]};
      chk("wordValid", 16'h1, {15'h0, gotValid});
      chk("wordOut", exp, gotWord);
      chk("trackMode", 16'h1, {15'h0, trackEnd});
      chk("trackMode", 16'h0, {15'h0, trackMid});
      chk("frameActive", 16'h1, {15'h0, activeMid});
      chk("frameActive", 16'h0, {15'h0, activeEnd});
    end
  endtask : t_full

  // Late abort keeps power, no word
  task automatic t_keep;
    logic [4:0] n [3] = '{5'd10, 5'd12, 5'd15};
    foreach (n[k])
    begin
      pwr(n[k], 1'h1);
      chk("wordValid", 16'h0, {15'h0, gotValid});
    end
  endtask : t_keep

  // Early rise is a glitch
  task automatic t_glitch;
    pwr(5'd1, 1'h1);
  endtask : t_glitch

  // Power down at both window ends, dummy frame wakes
  task automatic t_down;
    logic [4:0] n [2] = '{5'd2, 5'd9};
    foreach (n[k])
    begin
      pwr(n[k], 1'h0);
      pwr(5'd16, 1'h1);
      chk("trackMode", 16'h1, {15'h0, trackMid});
    end
  endtask : t_down

  // Dummy frames of nine and one falls leave it down, a twelve-fall dummy wakes it, then a valid word follows
  task automatic t_wake;
    pwr(5'd5, 1'h0);
    pwr(5'd9, 1'h0);
    pwr(5'd1, 1'h0);
    pwr(5'd16, 1'h1);
    pwr(5'd3, 1'h0);
    pwr(5'd12, 1'h1);
    sampleIn <= 12'h3c5;
    frame(5'd16);
    chk("wordOut", 16'h03c5, gotWord);
  endtask : t_wake

  // Main sequence
  initial
  begin
    clk         = 1'h0;
    reset_n     = 1'h0;
    startReq    = 1'h0;
    edgeCount   = 5'h0;
    sampleIn    = 12'h0;
    miscompares = 0;
    check_count = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'h1;
    #1;
    t_reset();
    t_full();
    t_keep();
    t_glitch();
    t_down();
    t_wake();
    tally_and_finish();
  end
endmodule : test_adc_frame_power_mode_control
`default_nettype wire

// ### rtl/afpmc_device.sv
// Converter end: frame counting, power mode, track/hold and result shifter
// Function
// - Sample and start conversion at frame-select fall
// - Host holds select low ten edges for power
// - Rise between ten and sixteen: abort, stay up
// - Full conversion and readout take sixteen clocks
// - Select may idle high or low between
// - Host waits quiet interval after output released
// - Rise between two and ten: power down
// - Rise before second edge keeps normal mode
// - Power-down switches off all analog circuitry
// - Fall starts power-up; sixteen clocks complete it
// - Early rise during power-up returns to power-down
// - Host uses one dummy conversion to power
// - Power-up: track on first clock edge after fall
// - Slow clock host may end dummy early
// - Supply-on mode unknown; dummy cycle sets it
// - Host need not wait before mode dummy
// - After supply-on track/hold already tracking
// - Word: four zeros, result MSB first, zero fill
// - Fall enables output; bits shift on falls
// - Output released at sixteenth falling edge
// - After thirteen falls, track on next rise
`timescale 1ns/10ps
`default_nettype none
module afpmc_device
  import afpmc_pkg::*;
#(
  parameter int unsigned RES_BITS = RESULT_BITS
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // Link to host
  afpmc_link_if.device             link,
  // Sampled analog value from the converter core
  input  wire logic [RES_BITS-1:0] sampleIn,
  // Status towards the analog core
  output logic                     poweredUp,
  output logic                     analogOn,
  output logic                     trackMode,
  output logic                     frameActive
);
  localparam int unsigned PAD = FRAME_EDGES - LEAD_ZEROS - RES_BITS;

  logic       selN;
  logic       selRise;
  logic       selFall;
  logic       clkSync;
  logic       clkRise;
  logic       clkFall;
  logic [4:0] fallCnt_r;
  logic [4:0] fallCnt_nxt;
  logic       active_r;
  logic       pwr_r;
  logic       pwrNext_r;
  logic       wake_r;
  logic       track_r;
  logic       trackArm_r;
  logic       outEn_r;
  logic       outBit_r;
  logic [15:0] shift_r;

  // Pin synchronisers
  afpmc_sync #(.RESET_VAL(1'h1)) uSel (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (link.frameSelN),
    .syncOut (selN),
    .riseOut (selRise),
    .fallOut (selFall)
  );

  afpmc_sync #(.RESET_VAL(1'h0)) uClk (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (link.serialClk),
    .syncOut (clkSync),
    .riseOut (clkRise),
    .fallOut (clkFall)
  );

  // Edge count decodes
  wire lastFall   = active_r & clkFall & (fallCnt_r == 5'(FRAME_EDGES - 1));
  wire earlyRise  = fallCnt_r < 5'(GLITCH_EDGES);
  wire midRise    = !earlyRise & (fallCnt_r < 5'(KEEP_EDGES));
  wire abortRise  = active_r & selRise;
  // Leading zeros above the result, zero fill below it
  wire [15:0] frameWord = 16'(sampleIn) << PAD;

  // Fall counter restarts at every frame start
  always_comb
  begin
    fallCnt_nxt = fallCnt_r;
    if (selFall)
      fallCnt_nxt = 5'h00;
    else if (active_r && clkFall && fallCnt_r != 5'h1f)
      fallCnt_nxt = fallCnt_r + 5'h01;
  end

  // Frame, power state and output control
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fallCnt_r <= 5'h00;
      active_r  <= 1'h0;
      pwr_r     <= PWR_UP_RESET;
      wake_r    <= 1'h0;
      outEn_r   <= 1'h0;
    end
    else
    begin
      fallCnt_r <= fallCnt_nxt;
      if (selFall)
      begin
        active_r <= 1'h1;
        outEn_r  <= 1'h1;
        wake_r   <= !pwr_r;
      end
      else if (abortRise)
      begin
        active_r <= 1'h0;
        outEn_r  <= 1'h0;
        wake_r   <= 1'h0;
        if (wake_r)
          pwr_r <= !(fallCnt_r < 5'(KEEP_EDGES));
        else if (midRise)
          pwr_r <= 1'h0;
        else if (earlyRise)
          pwr_r <= pwr_r;
      end
      else if (lastFall)
      begin
        active_r <= 1'h0;
        outEn_r  <= 1'h0;
        if (wake_r)
          pwr_r <= 1'h1;
        wake_r   <= 1'h0;
      end
    end
  end

  // Result word shifted out MSB first, first zero driven from the fall
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_r  <= 16'h0000;
      outBit_r <= 1'h0;
    end
    else if (selFall)
    begin
      shift_r  <= frameWord[15:0];
      outBit_r <= 1'h0;
    end
    else if (active_r && clkFall)
    begin
      shift_r  <= {shift_r[14:0], 1'h0};
      outBit_r <= shift_r[14];
    end
  end

  // Track and hold: hold from frame start, back to track per frame phase
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      track_r    <= 1'h1;
      trackArm_r <= 1'h0;
    end
    else if (selFall)
    begin
      track_r    <= 1'h0;
      trackArm_r <= 1'h0;
    end
    else if (active_r && wake_r && (clkRise || clkFall) && !trackArm_r)
    begin
      track_r    <= 1'h1;
      trackArm_r <= 1'h1;
    end
    else if (active_r && clkRise && fallCnt_r >= 5'(TRACK_EDGES))
      track_r <= 1'h1;
    else if (!active_r && !selN)
      track_r <= track_r;
    else if (!active_r)
      track_r <= 1'h1;
  end

  // Analog supply follows power state or a power-up in progress
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pwrNext_r <= PWR_UP_RESET;
    else
      pwrNext_r <= pwr_r | wake_r;
  end

  assign link.resultOut   = outBit_r;
  assign link.resultOutEn = outEn_r;
  assign poweredUp        = pwr_r;
  assign analogOn         = pwrNext_r;
  assign trackMode        = track_r;
  assign frameActive      = active_r;

  logic unusedClk;
  assign unusedClk = clkSync;
endmodule : afpmc_device
`default_nettype wire

// ### rtl/afpmc_host.sv
// Host end: frame select and serial clock generator, result capture
`timescale 1ns/10ps
`default_nettype none
module afpmc_host
  import afpmc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Link to converter
  afpmc_link_if.host       link,
  // User request: number of clock falls to send in this frame
  input  wire logic        startReq,
  input  wire logic [4:0]  edgeCount,
  // User answer
  output logic             busy,
  output logic             wordValid,
  output logic [15:0]      wordOut
);
  afpmc_host_type state_r;
  afpmc_host_type state_nxt;
  logic [4:0]  target_r;
  logic [4:0]  falls_r;
  logic [3:0]  div_r;
  logic [7:0]  quiet_r;
  logic        sclk_r;
  logic        sel_r;
  logic        busy_r;
  logic        valid_r;
  logic [15:0] shift_r;
  logic [15:0] word_r;
  logic        din;
  logic        dinRise;
  logic        dinFall;

  // Data pin synchroniser
  afpmc_sync #(.RESET_VAL(1'h0)) uDin (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn (link.resultOut),
    .syncOut (din),
    .riseOut (dinRise),
    .fallOut (dinFall)
  );

  wire divDone  = div_r == 4'(SCLK_HALF_CYC - 1);
  wire fallTick = divDone & sclk_r;
  wire doneRun  = falls_r == target_r;
  wire quietEnd = quiet_r == 8'(QUIET_CYC);

  // Sequencer: select low, clock bursts, quiet interval before next frame
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      AFPMC_IDLE:  if (startReq) state_nxt = AFPMC_LOW;
      AFPMC_LOW:   if (divDone) state_nxt = AFPMC_RUN;
      AFPMC_RUN:   if (doneRun && divDone && !sclk_r) state_nxt = AFPMC_QUIET;
      AFPMC_QUIET: if (quietEnd) state_nxt = AFPMC_IDLE;
      default:     state_nxt = AFPMC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r  <= AFPMC_IDLE;
      target_r <= 5'h00;
      falls_r  <= 5'h00;
      div_r    <= 4'h0;
      quiet_r  <= 8'h00;
      sclk_r   <= 1'h0;
      sel_r    <= 1'h1;
      busy_r   <= 1'h0;
      valid_r  <= 1'h0;
      shift_r  <= 16'h0000;
      word_r   <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      valid_r <= 1'h0;
      div_r   <= (state_r == AFPMC_IDLE || divDone) ? 4'h0 : div_r + 4'h1;
      case (state_r)
        AFPMC_IDLE:
        begin
          sel_r  <= !startReq;
          busy_r <= startReq;
          target_r <= (edgeCount > 5'(FRAME_EDGES)) ? 5'(FRAME_EDGES)
                                                    : edgeCount;
          falls_r <= 5'h00;
          quiet_r <= 8'h00;
        end
        AFPMC_RUN:
        begin
          if (divDone && !doneRun)
            sclk_r <= !sclk_r;
          if (fallTick)
          begin
            falls_r <= falls_r + 5'h01;
            shift_r <= {shift_r[14:0], din};
          end
          if (state_nxt == AFPMC_QUIET)
          begin
            sel_r   <= 1'h1;
            word_r  <= shift_r;
            valid_r <= target_r == 5'(FRAME_EDGES);
          end
        end
        AFPMC_QUIET:
        begin
          quiet_r <= quiet_r + 8'h01;
          busy_r  <= !quietEnd;
        end
        default:
        begin
          sclk_r <= 1'h0;
        end
      endcase
    end
  end

  assign link.frameSelN = sel_r;
  assign link.serialClk = sclk_r;
  assign busy           = busy_r;
  assign wordValid      = valid_r;
  assign wordOut        = word_r;

  logic unusedEdges;
  assign unusedEdges = dinRise ^ dinFall ^ link.resultOutEn;
endmodule : afpmc_host
`default_nettype wire

// ### rtl/afpmc_link_if.sv
// Link between host and converter: frame select, serial clock, data pin
`timescale 1ns/10ps
`default_nettype none
interface afpmc_link_if;
  logic frameSelN;      // Active-low frame select, host driven
  logic serialClk;      // Serial clock, host driven
  logic resultOut;      // serial_result_out level driven by the converter
  logic resultOutEn;    // High while the converter drives the data pin

  modport device (
    input  frameSelN,
    input  serialClk,
    output resultOut,
    output resultOutEn
  );

  modport host (
    output frameSelN,
    output serialClk,
    input  resultOut,
    input  resultOutEn
  );
endinterface : afpmc_link_if
`default_nettype wire

// ### rtl/afpmc_pkg.sv
// Shared constants and types for the converter frame and power-mode control
package afpmc_pkg;

  // Frame framing counts, in serial clock falling edges
  localparam int unsigned FRAME_EDGES   = 16;
  localparam int unsigned GLITCH_EDGES  = 2;
  localparam int unsigned KEEP_EDGES    = 10;
  localparam int unsigned TRACK_EDGES   = 13;
  localparam int unsigned LEAD_ZEROS    = 4;
  localparam int unsigned RESULT_BITS   = 12;

  // Quiet interval and power-up time, ns and derived cycles at 100 MHz
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned QUIET_NS       = 50;
  localparam int unsigned QUIET_CYC      = (QUIET_NS + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
  localparam int unsigned POWERUP_NS     = 1000;
  localparam int unsigned POWERUP_CYC    = (POWERUP_NS + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;

  // Host serial clock divider, half period in system cycles
  localparam int unsigned SCLK_HALF_CYC  = 4;

  // Power state after reset
  localparam logic        PWR_UP_RESET   = 1'h1;

  // Host sequencer states
  typedef enum logic [3:0] {
    AFPMC_IDLE  = 4'h1,
    AFPMC_LOW   = 4'h2,
    AFPMC_RUN   = 4'h4,
    AFPMC_QUIET = 4'h8
  } afpmc_host_type;

endpackage : afpmc_pkg

// ### rtl/afpmc_sync.sv
// Two-flop synchroniser with falling and rising edge pulses
`timescale 1ns/10ps
`default_nettype none
module afpmc_sync #(
  parameter logic RESET_VAL = 1'h0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Asynchronous level in, synchronous level and edges out
  input  wire logic asyncIn,
  output logic      syncOut,
  output logic      riseOut,
  output logic      fallOut
);
  logic stage1_r;
  logic stage2_r;
  logic stage3_r;

  // Stage one feeds only stage two
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1_r <= RESET_VAL;
      stage2_r <= RESET_VAL;
      stage3_r <= RESET_VAL;
    end
    else
    begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // Edge detection on synchronised copies only
  assign syncOut = stage2_r;
  assign riseOut = stage2_r & ~stage3_r;
  assign fallOut = ~stage2_r & stage3_r;
endmodule : afpmc_sync
`default_nettype wire
